// File: fifo_map.vh
// fifo_map.vh: constants shared by the buffer core and its helpers.
// assumes: included by bare name from each design file that needs it.
`ifndef FIFO_MAP_VH
`define FIFO_MAP_VH

// storage geometry
`define FIFO_AW 8
`define FIFO_DEPTH (1 << `FIFO_AW)
`define DATA_W 9
`define OFS_W 8
`define OFS_COUNT 4

// offset register sequence positions
`define SEQ_EMPTY_LOW 2'h0
`define SEQ_EMPTY_HIGH 2'h1
`define SEQ_FULL_LOW 2'h2
`define SEQ_FULL_HIGH 2'h3

// offset reset values
`define OFS_DEFAULT_LOW 8'h07
`define OFS_DEFAULT_HIGH 8'h00

// pin sampling bus layout
`define PIN_W 17
`define PIN_WCLK 16
`define PIN_RCLK 15
`define PIN_RST_N 14
`define PIN_WEA_N 13
`define PIN_WEB 12
`define PIN_REA_N 11
`define PIN_REB_N 10
`define PIN_OE_N 9
`define PIN_DATA_HI 8
`define PIN_DATA_LO 0
`define PIN_RESET_VAL 17'h0_2e00

// output staging buffer
`define BUF_EMPTY 2'h0
`define BUF_ONE 2'h1
`define BUF_FULL 2'h2

`endif

// File: pin_sync.v
// pin_sync.v: two-stage sampler for a bus of asynchronous pins.
// assumes: every bit is sampled alike; no logic reads the first stage.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 17,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_in, // sampling clock
  input wire rst_in, // async reset, active high
  input wire [WIDTH-1:0] async_in, // raw pins
  output wire [WIDTH-1:0] sync_out // sampled pins
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // first stage feeds only the second, to settle metastability
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule
`default_nettype wire

// File: two_entry_buffer.v
// two_entry_buffer.v: two-word staging buffer with valid/ready both sides.
// assumes: one clock; flush empties it without a handshake.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_map.vh"

module two_entry_buffer #(
  parameter WIDTH = 9
) (
  input wire clk_in, // clock
  input wire rst_in, // async reset, active high
  input wire flush_in, // drop all words
  input wire in_valid_in, // word offered
  output wire in_ready_out, // room for a word
  input wire [WIDTH-1:0] in_data_in, // offered word
  output wire out_valid_out, // head word present
  input wire out_ready_in, // head word taken
  output wire [WIDTH-1:0] out_data_out // head word
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0] fill;
  wire push;
  wire pop;

  assign in_ready_out = (fill != `BUF_FULL);
  assign out_valid_out = (fill != `BUF_EMPTY);
  assign out_data_out = slot0;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // slot0 is always the head, so the output is straight from a flop
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      fill <= `BUF_EMPTY;
    end else if (flush_in) begin
      fill <= `BUF_EMPTY;
    end else if (push && pop) begin
      if (fill == `BUF_ONE) begin
        slot0 <= in_data_in;
      end else begin
        slot0 <= slot1;
        slot1 <= in_data_in;
      end
    end else if (pop) begin
      slot0 <= slot1;
      fill <= fill - `BUF_ONE;
    end else if (push) begin
      if (fill == `BUF_EMPTY) begin
        slot0 <= in_data_in;
      end else begin
        slot1 <= in_data_in;
      end
      fill <= fill + `BUF_ONE;
    end
  end

endmodule
`default_nettype wire

// File: dual_clock_fifo_prog_flags.v
// dual_clock_fifo_prog_flags.v: 9-bit first-in first-out buffer with
// empty, full and programmable almost flags and four offset registers.
// assumes: all device pins, the write and read clocks among them, are
// asynchronous to clk_in and are sampled by it; each pin clock runs
// well below half of clk_in so every edge is seen.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_map.vh"

module dual_clock_fifo_prog_flags (
  input wire clk_in, // system clock, 25 MHz
  input wire sys_rst_in, // async reset, active high
  input wire reset_n_in, // device reset pin, active low
  input wire write_clock_in, // write clock pin
  input wire read_clock_in, // read clock pin
  input wire write_enable_a_n_in, // write enable a, active low
  input wire write_enable_b_or_load_in, // enable b or load_n
  input wire read_enable_a_n_in, // read enable a, active low
  input wire read_enable_b_n_in, // read enable b, active low
  input wire output_enable_n_in, // output enable, active low
  input wire [8:0] input_bus_in, // write data
  output wire [8:0] output_bus_out, // output register
  output wire output_bus_oe_n_out, // low while bus driven
  output wire full_n_out, // full flag, active low
  output wire almost_full_n_out, // almost-full, active low
  output wire empty_n_out, // empty flag, active low
  output wire almost_empty_n_out // almost-empty, active low
);

  localparam AW = `FIFO_AW;
  localparam PW = `FIFO_AW + 1;
  localparam DW = `DATA_W;
  localparam OW = `OFS_W;
  localparam [PW-1:0] PTR_ZERO = {PW{1'b0}};
  localparam [PW-1:0] PTR_ONE = {{AW{1'b0}}, 1'b1};
  // depth built at pointer width, so no wide integer is cut silently
  localparam [PW-1:0] DEPTH_P = PTR_ONE << AW;

  //////////////////////////////////////////////////////////////////////
  // pointer coding helpers

  // binary to gray, so only one bit moves per step
  function [PW-1:0] bin2gray;
    input [PW-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  // gray back to binary, one xor chain
  function [PW-1:0] gray2bin;
    input [PW-1:0] g;
    integer i;
    begin
      gray2bin[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin sampling

  wire [`PIN_W-1:0] pin_raw;
  wire [`PIN_W-1:0] pin_s;

  assign pin_raw = {write_clock_in, read_clock_in, reset_n_in,
                    write_enable_a_n_in, write_enable_b_or_load_in,
                    read_enable_a_n_in, read_enable_b_n_in,
                    output_enable_n_in, input_bus_in};

  // data and controls travel with the clocks, so they stay aligned
  pin_sync #(
    .WIDTH(`PIN_W),
    .RESET_VAL(`PIN_RESET_VAL)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  wire dev_rst;
  wire wea_n_s;
  wire web_s;
  wire rea_n_s;
  wire reb_n_s;
  wire [DW-1:0] din_s;

  assign dev_rst = ~pin_s[`PIN_RST_N];
  assign wea_n_s = pin_s[`PIN_WEA_N];
  assign web_s = pin_s[`PIN_WEB];
  assign rea_n_s = pin_s[`PIN_REA_N];
  assign reb_n_s = pin_s[`PIN_REB_N];
  assign din_s = pin_s[`PIN_DATA_HI:`PIN_DATA_LO];

  //////////////////////////////////////////////////////////////////////
  // pin clock edges

  reg wclk_prev;
  reg rclk_prev;
  wire wr_edge;
  wire rd_edge;

  // previous sampled level, for rising edge detection
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wclk_prev <= 1'b0;
      rclk_prev <= 1'b0;
    end else begin
      wclk_prev <= pin_s[`PIN_WCLK];
      rclk_prev <= pin_s[`PIN_RCLK];
    end
  end

  // sides act only on their own rising edges
  assign wr_edge = pin_s[`PIN_WCLK] & ~wclk_prev;
  assign rd_edge = pin_s[`PIN_RCLK] & ~rclk_prev;

  //////////////////////////////////////////////////////////////////////
  // mode strap

  reg mode_two_we;

  // strap caught by the clock while the device reset is held
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_two_we <= 1'b0;
    end else if (dev_rst) begin
      mode_two_we <= web_s;
    end
  end

  wire load_act;
  assign load_act = ~mode_two_we & ~web_s; // load only in flag mode

  //////////////////////////////////////////////////////////////////////
  // offset registers

  reg [OW-1:0] ofs_reg [0:`OFS_COUNT-1];
  reg [1:0] ofs_sel;
  wire ofs_wr;
  wire ofs_rd;
  wire [2*OW-1:0] empty_ofs;
  wire [2*OW-1:0] full_ofs;
  wire [PW-1:0] n_ofs;
  wire [PW-1:0] m_ofs;

  assign ofs_wr = wr_edge & ~dev_rst & load_act & ~wea_n_s;
  assign ofs_rd = rd_edge & ~dev_rst & load_act
                & ~rea_n_s & ~reb_n_s;

  // one element per block; high bytes reset to their own default
  genvar g;
  generate
    for (g = 0; g < `OFS_COUNT; g = g + 1) begin : ofs_bank
      localparam [1:0] IDX = g;
      always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          ofs_reg[g] <= IDX[0] ? `OFS_DEFAULT_HIGH : `OFS_DEFAULT_LOW;
        end else if (dev_rst) begin
          ofs_reg[g] <= IDX[0] ? `OFS_DEFAULT_HIGH : `OFS_DEFAULT_LOW;
        end else if (ofs_wr && (ofs_sel == IDX)) begin
          ofs_reg[g] <= din_s[OW-1:0];
        end
      end
    end
  endgenerate

  // shared position; load rising leaves it where it is
  // a read and a write in one cycle step it only once between them
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ofs_sel <= `SEQ_EMPTY_LOW;
    end else if (dev_rst) begin
      ofs_sel <= `SEQ_EMPTY_LOW;
    end else if (ofs_wr || ofs_rd) begin
      ofs_sel <= ofs_sel + 2'h1; // wraps full-high to empty-low
    end
  end

  // high bits beyond the depth are dropped
  assign empty_ofs = {ofs_reg[`SEQ_EMPTY_HIGH], ofs_reg[`SEQ_EMPTY_LOW]};
  assign full_ofs = {ofs_reg[`SEQ_FULL_HIGH], ofs_reg[`SEQ_FULL_LOW]};
  assign n_ofs = {1'b0, empty_ofs[AW-1:0]};
  assign m_ofs = {1'b0, full_ofs[AW-1:0]};

  //////////////////////////////////////////////////////////////////////
  // write side

  reg [DW-1:0] mem [0:`FIFO_DEPTH-1];
  reg [PW-1:0] wptr;
  reg [PW-1:0] wgray;
  reg [PW-1:0] rg_s1;
  reg [PW-1:0] rg_s2;
  reg full_n;
  reg almost_full_n;
  reg [PW-1:0] rgray;
  wire fifo_wr;
  wire [PW-1:0] next_wptr;
  wire [PW-1:0] rptr_w;
  wire [PW-1:0] wcount;
  wire [PW-1:0] next_wcount;

  // enable b high is required in both modes: in flag mode it is load_n
  assign fifo_wr = wr_edge & ~dev_rst & full_n
                 & ~wea_n_s & web_s;
  assign next_wptr = wptr + PTR_ONE;

  // storage array, written only on accepted writes
  always @(posedge clk_in) begin
    if (fifo_wr) begin
      mem[wptr[AW-1:0]] <= din_s;
    end
  end

  // write pointer and its gray copy
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wptr <= PTR_ZERO;
      wgray <= PTR_ZERO;
    end else if (dev_rst) begin
      wptr <= PTR_ZERO;
      wgray <= PTR_ZERO;
    end else if (fifo_wr) begin
      wptr <= next_wptr;
      wgray <= bin2gray(next_wptr);
    end
  end

  // read pointer crosses as gray through two stages
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rg_s1 <= PTR_ZERO;
      rg_s2 <= PTR_ZERO;
    end else begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
    end
  end

  assign rptr_w = gray2bin(rg_s2);
  assign wcount = wptr - rptr_w;
  assign next_wcount = fifo_wr ? (next_wptr - rptr_w) : wcount;

  // stale read pointer only overstates the count: never late to assert
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      full_n <= 1'b1;
      almost_full_n <= 1'b1;
    end else if (dev_rst) begin
      full_n <= 1'b1;
      almost_full_n <= 1'b1;
    end else if (wr_edge) begin
      full_n <= ~(next_wcount == DEPTH_P);
      almost_full_n <= ~(next_wcount >= (DEPTH_P - m_ofs));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read side prefetch

  reg [PW-1:0] wg_s1;
  reg [PW-1:0] wg_s2;
  reg [PW-1:0] fptr;
  wire [PW-1:0] wptr_r;
  wire pf_valid;
  wire pf_ready;
  wire buf_valid;
  wire [DW-1:0] buf_data;
  wire fifo_rd;

  // write pointer crosses as gray through two stages
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wg_s1 <= PTR_ZERO;
      wg_s2 <= PTR_ZERO;
    end else begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
    end
  end

  assign wptr_r = gray2bin(wg_s2);
  assign pf_valid = ~dev_rst & (fptr != wptr_r);

  // fetch pointer stalls whenever the staging buffer is full
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fptr <= PTR_ZERO;
    end else if (dev_rst) begin
      fptr <= PTR_ZERO;
    end else if (pf_valid && pf_ready) begin
      fptr <= fptr + PTR_ONE;
    end
  end

  // words wait here until a read edge takes them
  two_entry_buffer #(
    .WIDTH(DW)
  ) u_stage (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .flush_in(dev_rst),
    .in_valid_in(pf_valid),
    .in_ready_out(pf_ready),
    .in_data_in(mem[fptr[AW-1:0]]),
    .out_valid_out(buf_valid),
    .out_ready_in(fifo_rd),
    .out_data_out(buf_data)
  );

  //////////////////////////////////////////////////////////////////////
  // read side pointer, flags and output register

  reg [PW-1:0] rptr;
  reg empty_n;
  reg almost_empty_n;
  reg [DW-1:0] out_reg;
  wire [PW-1:0] next_rptr;
  wire [PW-1:0] rcount;
  wire [PW-1:0] next_rcount;

  // reads ignored while empty or while load shows offsets
  assign fifo_rd = rd_edge & ~dev_rst & ~load_act & ~rea_n_s
                 & ~reb_n_s & empty_n & buf_valid;
  assign next_rptr = rptr + PTR_ONE;
  assign rcount = wptr_r - rptr;
  assign next_rcount = fifo_rd ? (wptr_r - next_rptr) : rcount;

  // committed read pointer and its gray copy
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rptr <= PTR_ZERO;
      rgray <= PTR_ZERO;
    end else if (dev_rst) begin
      rptr <= PTR_ZERO;
      rgray <= PTR_ZERO;
    end else if (fifo_rd) begin
      rptr <= next_rptr;
      rgray <= bin2gray(next_rptr);
    end
  end

  // stale write pointer only understates: empty never late
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      empty_n <= 1'b0;
      almost_empty_n <= 1'b0;
    end else if (dev_rst) begin
      empty_n <= 1'b0;
      almost_empty_n <= 1'b0;
    end else if (rd_edge) begin
      empty_n <= (next_rcount != PTR_ZERO);
      almost_empty_n <= ~(next_rcount <= n_ofs);
    end
  end

  // output register holds unless a word or an offset is read
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_reg <= {DW{1'b0}};
    end else if (dev_rst) begin
      out_reg <= {DW{1'b0}};
    end else if (fifo_rd) begin
      out_reg <= buf_data;
    end else if (ofs_rd) begin
      out_reg <= {1'b0, ofs_reg[ofs_sel]};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  // bus drive follows the sampled output enable pin
  assign output_bus_out = out_reg;
  assign output_bus_oe_n_out = pin_s[`PIN_OE_N];
  assign full_n_out = full_n;
  assign almost_full_n_out = almost_full_n;
  assign empty_n_out = empty_n;
  assign almost_empty_n_out = almost_empty_n;

endmodule
`default_nettype wire

// File: fifo_checks_assertions.sv
// fifo_checks_assertions.sv: pin-level properties of the nine-bit buffer.
// assumes: bound to the buffer top; pin clocks hold each level >= 4 cycles.
`timescale 1ns/1ps
`default_nettype none

module fifo_checks (
  input wire clk_in, // system clock
  input wire sys_rst_in, // async reset, high
  input wire reset_n_in, // device reset pin
  input wire write_clock_in, // write clock pin
  input wire read_clock_in, // read clock pin
  input wire write_enable_b_or_load_in, // enable b or load_n
  input wire output_enable_n_in, // output enable pin
  input wire [8:0] output_bus_out, // output register
  input wire output_bus_oe_n_out, // bus drive enable
  input wire full_n_out, // full flag
  input wire almost_full_n_out, // almost-full flag
  input wire empty_n_out, // empty flag
  input wire almost_empty_n_out // almost-empty flag
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////////////////////////////////////
  // reset pin needs ~3 cycles through its sampler before it takes hold
  reset_flags_a: assert property (!reset_n_in [*6] |-> full_n_out
    && almost_full_n_out && !empty_n_out && !almost_empty_n_out && output_bus_out == 9'h000)
    else $error("flags or output not at reset values");
  oe_follow_a: assert property ($stable(output_enable_n_in) [*6]
    |-> output_bus_oe_n_out == output_enable_n_in)
    else $error("bus enable does not follow output enable");
  full_af_a: assert property (!full_n_out |-> !almost_full_n_out)
    else $error("full without almost full");
  empty_ae_a: assert property (!empty_n_out |-> !almost_empty_n_out)
    else $error("empty without almost empty");

  ////////////////////////////////////////////////////////////////////////
  // flags and the output register move only after an edge of their own side's clock
  full_quiet_a: assert property ((!write_clock_in && reset_n_in) [*8]
    |=> $stable(full_n_out) && $stable(almost_full_n_out))
    else $error("write side flag moved without write edge");
  empty_quiet_a: assert property ((!read_clock_in && reset_n_in) [*8]
    |=> $stable(empty_n_out) && $stable(almost_empty_n_out))
    else $error("read side flag moved without read edge");
  out_quiet_a: assert property ((!read_clock_in && reset_n_in) [*8]
    |=> $stable(output_bus_out))
    else $error("output register moved without read edge");
  // a word leaves only when not empty, unless the offsets are being read
  empty_refuse_a: assert property ($changed(output_bus_out) && reset_n_in
    && $past(reset_n_in, 5) |-> $past(empty_n_out) || !$past(write_enable_b_or_load_in, 4))
    else $error("output changed while empty");
endmodule

bind dual_clock_fifo_prog_flags fifo_checks i_fifo_checks (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reset_n_in(reset_n_in),
  .write_clock_in(write_clock_in), .read_clock_in(read_clock_in),
  .write_enable_b_or_load_in(write_enable_b_or_load_in),
  .output_enable_n_in(output_enable_n_in), .output_bus_out(output_bus_out),
  .output_bus_oe_n_out(output_bus_oe_n_out), .full_n_out(full_n_out),
  .almost_full_n_out(almost_full_n_out), .empty_n_out(empty_n_out),
  .almost_empty_n_out(almost_empty_n_out));
`default_nettype wire

// File: fifo_pin_partner.sv
// fifo_pin_partner.sv: writer and reader logic driving the buffer pins.
// assumes: clk_in is the buffer's sampling clock; calls never overlap.
`timescale 1ns/1ps
`default_nettype none

module fifo_pin_partner (
  input wire clk_in, // sampling clock
  input wire [8:0] q_bus_in, // resolved output bus
  output logic reset_n_out, // device reset
  output logic write_clock_out, // write clock, idle low
  output logic read_clock_out, // read clock, idle low
  output logic write_enable_a_n_out, // write enable a
  output logic write_enable_b_or_load_out, // enable b or load_n
  output logic read_enable_a_n_out, // read enable a
  output logic read_enable_b_n_out, // read enable b
  output logic output_enable_n_out, // output enable
  output logic [8:0] input_bus_out, // write data
  input wire [2:0] op_in, // requested operation
  input wire [10:0] arg_in, // read enable b, enable a, data
  input wire go_in, // request raised
  output logic done_out, // request finished
  output logic [8:0] q_out // word caught by the last read
);
  localparam logic [2:0] OP_RST = 3'h0;
  localparam logic [2:0] OP_B = 3'h1;
  localparam logic [2:0] OP_OE = 3'h2;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_RD = 3'h4;
  // held in reset from time zero so no write precedes a reset
  initial begin
    reset_n_out = 1'b0;
    write_clock_out = 1'b0;
    read_clock_out = 1'b0;
    write_enable_a_n_out = 1'b1;
    write_enable_b_or_load_out = 1'b0;
    read_enable_a_n_out = 1'b1;
    read_enable_b_n_out = 1'b1;
    output_enable_n_out = 1'b0;
    input_bus_out = 9'h000;
    done_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // four cycles per level so the two-flop samplers see each one
  task automatic settle();
    repeat (4) @(negedge clk_in);
  endtask
  task automatic pulse_reset(input logic b);
    @(negedge clk_in);
    write_enable_b_or_load_out = b;
    reset_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    reset_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
  task automatic set_b(input logic b);
    @(negedge clk_in);
    write_enable_b_or_load_out = b;
    settle();
  endtask
  task automatic set_oe(input logic oe_n);
    @(negedge clk_in);
    output_enable_n_out = oe_n;
    settle();
  endtask
  // one write edge; released data shows its inverse, not the old value
  task automatic wr(input logic a_n, input logic [8:0] d);
    @(negedge clk_in);
    write_enable_a_n_out = a_n;
    input_bus_out = d;
    write_clock_out = 1'b1;
    settle();
    write_clock_out = 1'b0;
    write_enable_a_n_out = 1'b1;
    input_bus_out = ~d;
    settle();
  endtask
  // reads and writes run one after the other, never together
  task automatic rd(input logic a_n, input logic b_n, output logic [8:0] q);
    @(negedge clk_in);
    read_enable_a_n_out = a_n;
    read_enable_b_n_out = b_n;
    read_clock_out = 1'b1;
    settle();
    read_clock_out = 1'b0;
    read_enable_a_n_out = 1'b1;
    read_enable_b_n_out = 1'b1;
    settle();
    q = q_bus_in;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one operation per raise of go_in; done_out drops only after go_in
  // falls, so a request is neither lost nor run twice
  always @(posedge go_in) begin
    case (op_in)
      OP_RST: pulse_reset(arg_in[0]);
      OP_B: set_b(arg_in[0]);
      OP_OE: set_oe(arg_in[0]);
      OP_WR: wr(arg_in[9], arg_in[8:0]);
      OP_RD: rd(arg_in[9], arg_in[10], q_out);
      default: settle();
    endcase
    done_out = 1'b1;
    wait (!go_in);
    done_out = 1'b0;
  end
endmodule
`default_nettype wire

// File: dual_clock_fifo_prog_flags_bench.sv
// dual_clock_fifo_prog_flags_bench.sv: self-checking bench for the buffer.
// assumes: partner drives every pin; the bench resolves the output bus.
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_prog_flags_bench;
  logic clk_in;
  logic sys_rst_in;
  logic [8:0] q;
  int fails;
  int checks_done;
  int i;
  localparam logic [2:0] OP_RST = 3'h0;
  localparam logic [2:0] OP_B = 3'h1;
  localparam logic [2:0] OP_OE = 3'h2;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_RD = 3'h4;
  logic [2:0] op;
  logic [10:0] arg;
  logic go;
  wire done;
  wire [8:0] q_p;
  wire rst_n, wclk, rclk, wea_n, web, rea_n, reb_n, oe_n, oe_n_o;
  wire full_n, af_n, empty_n, ae_n;
  wire [8:0] din, dout;
  // bus floats whenever the block releases it
  wire [8:0] q_bus = oe_n_o ? 9'hzzz : dout;

  dual_clock_fifo_prog_flags i_dual_clock_fifo_prog_flags (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .reset_n_in(rst_n), .write_clock_in(wclk),
    .read_clock_in(rclk), .write_enable_a_n_in(wea_n), .write_enable_b_or_load_in(web),
    .read_enable_a_n_in(rea_n), .read_enable_b_n_in(reb_n), .output_enable_n_in(oe_n),
    .input_bus_in(din), .output_bus_out(dout), .output_bus_oe_n_out(oe_n_o),
    .full_n_out(full_n), .almost_full_n_out(af_n), .empty_n_out(empty_n),
    .almost_empty_n_out(ae_n));
  fifo_pin_partner partner (.clk_in(clk_in), .q_bus_in(q_bus), .reset_n_out(rst_n),
    .write_clock_out(wclk), .read_clock_out(rclk), .write_enable_a_n_out(wea_n),
    .write_enable_b_or_load_out(web), .read_enable_a_n_out(rea_n),
    .read_enable_b_n_out(reb_n), .output_enable_n_out(oe_n), .input_bus_out(din),
    .op_in(op), .arg_in(arg), .go_in(go), .done_out(done), .q_out(q_p));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] word(input int k);
    word = k[8:0] ^ 9'h155;
  endfunction
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // requests reach the pin model by a four-phase handshake, one at a time
  task automatic act(input logic [2:0] k, input logic [10:0] a);
    @(posedge clk_in);
    op = k;
    arg = a;
    go = 1'b1;
    wait (done);
    go = 1'b0;
    wait (!done);
  endtask
  task automatic pulse_reset(input logic b);
    act(OP_RST, {10'h000, b});
  endtask
  task automatic set_b(input logic b);
    act(OP_B, {10'h000, b});
  endtask
  task automatic set_oe(input logic oe_n_v);
    act(OP_OE, {10'h000, oe_n_v});
  endtask
  task automatic wr(input logic a_n, input logic [8:0] d);
    act(OP_WR, {1'b1, a_n, d});
  endtask
  task automatic rd(input logic a_n, input logic b_n, output logic [8:0] v);
    act(OP_RD, {b_n, a_n, 9'h000});
    v = q_p;
  endtask

  task automatic t_reset();
    pulse_reset(1'b0);
    chk("flags", {5'h00, full_n, af_n, empty_n, ae_n}, 9'h00c);
    chk("bus", q_bus, 9'h000);
    $display("test reset done");
  endtask
  // n = 3 with junk high byte, m = 5; load raised between halves
  task automatic t_offsets();
    logic [8:0] ofs_exp [4];
    ofs_exp = '{9'h003, 9'h0a5, 9'h005, 9'h000};
    wr(1'b0, 9'h003);
    wr(1'b0, 9'h1a5);
    set_b(1'b1);
    set_b(1'b0);
    wr(1'b0, 9'h005);
    wr(1'b0, 9'h000);
    for (i = 0; i < 4; i++) begin
      rd(1'b0, 1'b0, q);
      chk("offset", q, ofs_exp[i]);
    end
    set_b(1'b1);
    $display("test offsets done");
  endtask
  task automatic t_fill();
    for (i = 0; i < 256; i++) begin
      wr(1'b0, word(i));
      chk("almost_full_n", af_n, (i + 1 >= 251) ? 9'h000 : 9'h001);
      chk("full_n", full_n, (i == 255) ? 9'h000 : 9'h001);
    end
    wr(1'b0, 9'h1aa);
    chk("full_n", full_n, 9'h000);
    $display("test fill done");
  endtask
  task automatic t_drain();
    rd(1'b1, 1'b1, q);
    chk("empty_n", empty_n, 9'h001);
    chk("almost_empty_n", ae_n, 9'h001);
    rd(1'b0, 1'b0, q);
    chk("data", q, word(0));
    wr(1'b1, 9'h000);
    chk("full_n", full_n, 9'h001);
    chk("almost_full_n", af_n, 9'h000);
    for (i = 2; i <= 256; i++) begin
      rd(1'b0, 1'b0, q);
      chk("data", q, word(i - 1));
      chk("almost_empty_n", ae_n, (256 - i <= 3) ? 9'h000 : 9'h001);
      chk("empty_n", empty_n, (i == 256) ? 9'h000 : 9'h001);
    end
    rd(1'b0, 1'b0, q);
    chk("data", q, word(255));
    $display("test drain done");
  endtask
  task automatic t_oe();
    set_oe(1'b1);
    chk("oe_n", oe_n_o, 9'h001);
    chk("bus", q_bus, 9'hzzz);
    set_oe(1'b0);
    chk("bus", q_bus, word(255));
    $display("test output enable done");
  endtask
  // word left behind must vanish with the second reset
  task automatic t_two_enable();
    wr(1'b0, 9'h077);
    pulse_reset(1'b1);
    rd(1'b1, 1'b1, q);
    chk("empty_n", empty_n, 9'h000);
    wr(1'b0, 9'h123);
    set_b(1'b0);
    wr(1'b0, 9'h0f0);
    set_b(1'b1);
    wr(1'b1, 9'h0aa);
    wr(1'b0, 9'h0c3);
    rd(1'b1, 1'b1, q);
    rd(1'b0, 1'b0, q);
    chk("data", q, 9'h123);
    rd(1'b0, 1'b1, q);
    chk("data", q, 9'h123);
    rd(1'b0, 1'b0, q);
    chk("data", q, 9'h0c3);
    chk("empty_n", empty_n, 9'h000);
    $display("test two enables done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // the whole run needs about 4900 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    wrap_up();
  end
  initial begin
    fails = 0;
    checks_done = 0;
    go = 1'b0;
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_offsets();
    t_fill();
    t_drain();
    t_oe();
    t_two_enable();
    wrap_up();
  end
endmodule
`default_nettype wire
